/* File: verilog/pefir_regs.svh */
/*
 Register indexes, field positions, reset values and fixed-point constants
 of the programmable equalizer filter. Assumes a word-addressed Wishbone
 slave: byte address is four times the index given here.
*/
// Operation
// [RQ1] Share bit set makes channel B use channel A coefficients, else its own.
// [RQ2] Merge bit set runs both filters as one over the interleaved A/B stream; the code keeps the B set for output B unless share is also set.
// [RQ3] Software sets the merge bit whenever the converter runs single-channel.
// [RQ4] Three-bit side weight gives coefficient LSB weight two to (value minus 16); the code clips value 7 to 6.
// [RQ5] Side weight scales every tap except the center tap.
// [RQ6] Mode field 0 disables, 2 enables; 1 and 3 are reserved.
// [RQ7] Software loads the tap coefficients whenever it enables the filter.
// [RQ8] Software changes filter registers only while the serial link is off.
// [RQ9] Side tap registers hold signed 12-bit values; bits 15:12 reserved.
// [RQ10] Index 0x418 holds the first tap of channel A or the merged filter.
// [RQ11] Index 0x41A holds the second tap of channel A or the merged filter.
// [RQ12] Configuration register resets to zero: off, unshared, unmerged, weight 0.
// [RQ13] Index 0x41C holds the third tap of channel A or the merged filter.
// [RQ14] Nine taps; the center tap coefficient is 18 bits wide.
// [RQ15] Disabled passes samples unchanged; enabled outputs weighted sum of nine.
`ifndef PEFIR_REGS_SVH
`define PEFIR_REGS_SVH

`define PEF_IDX_CFG     11'h400
`define PEF_IDX_A0      11'h418
`define PEF_IDX_A1      11'h41a
`define PEF_IDX_A2      11'h41c
`define PEF_IDX_STEP    11'h002
`define PEF_IDX_B_BASE  11'h430
`define PEF_IDX_STAT    11'h450

`define PEF_CFG_RST     7'h00
`define PEF_MODE_OFF    2'h0
`define PEF_MODE_ON     2'h2
`define PEF_SCW_MAX     3'h6
`define PEF_TAPS        9
`define PEF_CENTER      4
`define PEF_FRAC        16
`define PEF_SIDE_MASK   18'h00fff
`define PEF_CTR_MASK    18'h3ffff
`define PEF_SAT_MAX     40'sh00000007ff
`define PEF_SAT_MIN     -40'sh0000000800

`define PEF_STAT_LINK   0
`define PEF_STAT_BADWR  1
`define PEF_STAT_ACTIVE 2

`endif

/* File: verilog/pefir_pkg.sv */
/*
 Types shared by the equalizer filter files. Assumes the constants of
 pefir_regs.svh; nothing is imported, users write pefir_pkg::name.
*/
package pefir_pkg;
    typedef struct packed {
        logic       share;
        logic       merge;
        logic [2:0] scw;
        logic [1:0] mode;
    } pefir_cfg_s;

    typedef struct packed {
        logic [11:0] b;
        logic [11:0] a;
    } pefir_pair_s;

    typedef logic [8:0][11:0] pefir_win_t;
    typedef logic [8:0][17:0] pefir_coef_t;
endpackage : pefir_pkg

/* File: verilog/pefir_top.sv */
/*
 Programmable nine-tap equalizer for two converter channels with its
 Wishbone register file and an output FIFO. Assumes one clock, a
 synchronous active-low reset and a classic Wishbone master.
*/
// Design decision made here: the Wishbone interface to the registers.
`include "pefir_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module pefir_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wp_q;
    logic [AW:0]      wp_d;
    logic [AW:0]      rp_q;
    logic [AW:0]      rp_d;
    logic             push;
    logic             pop;

    // Pointer wrap relies on a power-of-two depth
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("FIFO depth must be a power of two");
    end

    // Extra pointer bit tells full from empty
    assign in_ready  = !((wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]));
    assign out_valid = (wp_q != rp_q);
    assign out_data  = mem_q[rp_q[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Pointer next values
    always_comb begin
        wp_d = push ? wp_q + 1'b1 : wp_q;
        rp_d = pop ? rp_q + 1'b1 : rp_q;
    end

    // Storage holds no reset; only the pointers need one
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wp_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
        end
    end
endmodule : pefir_fifo

module pefir_top #(
    parameter int TAPS       = `PEF_TAPS,
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic        CLK_SYS,
    input  wire logic        RST_N,
    input  wire logic [12:0] WB_ADR_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    input  wire logic        WB_WE_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_CYC_I,
    output logic             WB_ACK_O,
    input  wire logic        SERIAL_LINK_ENABLE,
    input  wire logic        SMP_VALID,
    output logic             SMP_READY,
    input  wire logic [11:0] SMP_A,
    input  wire logic [11:0] SMP_B,
    output logic             OUT_VALID,
    input  wire logic        OUT_READY,
    output logic      [11:0] OUT_A,
    output logic      [11:0] OUT_B
);
    pefir_pkg::pefir_cfg_s  cfg_q;
    pefir_pkg::pefir_cfg_s  cfg_d;
    pefir_pkg::pefir_coef_t coef_a_q;
    pefir_pkg::pefir_coef_t coef_a_d;
    pefir_pkg::pefir_coef_t coef_b_q;
    pefir_pkg::pefir_coef_t coef_b_d;
    pefir_pkg::pefir_coef_t coef_b_use;
    pefir_pkg::pefir_win_t  ha_q;
    pefir_pkg::pefir_win_t  ha_d;
    pefir_pkg::pefir_win_t  hb_q;
    pefir_pkg::pefir_win_t  hb_d;
    pefir_pkg::pefir_win_t  win_a;
    pefir_pkg::pefir_win_t  win_b;
    pefir_pkg::pefir_pair_s res;
    pefir_pkg::pefir_pair_s fifo_out;
    logic        pend_q;
    logic        pend_d;
    logic        ack_q;
    logic        ack_d;
    logic [31:0] rdat_q;
    logic [31:0] rdat_d;
    logic        badwr_q;
    logic        badwr_d;
    logic        fifo_in_ready;
    logic        wb_req;
    logic        wb_wr;
    logic        mapped;
    logic [10:0] idx;
    logic        smp_take;
    logic        enabled;
    logic [2:0]  scw_eff;

    // History and window wiring are built for the nine-tap layout only
    if (TAPS != `PEF_TAPS) begin : g_bad_taps
        $error("Equalizer supports exactly nine taps");
    end

    // Byte-lane merge of a write into an existing word
    function automatic logic [31:0] lane_mix(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return r;
    endfunction : lane_mix

    // Weighted sum; side products carry the extra weight, center keeps 2^-16
    function automatic logic [11:0] fir_eval(input pefir_pkg::pefir_win_t  w,
                                             input pefir_pkg::pefir_coef_t c,
                                             input logic [2:0]              scw);
        logic signed [39:0] acc;
        logic signed [39:0] p;
        logic signed [39:0] r;
        acc = '0;
        for (int k = 0; k < `PEF_TAPS; k++) begin
            if (k == `PEF_CENTER) begin
                p = 40'(signed'(c[k])) * 40'(signed'(w[k])); // see [RQ14]
            end else begin
                p = (40'(signed'(c[k][11:0])) * 40'(signed'(w[k]))) <<< scw; // see [RQ4] see [RQ5]
            end
            acc = acc + p;
        end
        r = acc >>> `PEF_FRAC;
        // Saturate rather than wrap so a hot coefficient set clips cleanly
        if (r > `PEF_SAT_MAX) begin
            return 12'h7ff;
        end else if (r < `PEF_SAT_MIN) begin
            return 12'h800;
        end else begin
            return r[11:0];
        end
    endfunction : fir_eval

    // Bus decode: one wait state, ack registered
    assign idx    = WB_ADR_I[12:2];
    assign wb_req = WB_CYC_I && WB_STB_I && !ack_q;
    assign wb_wr  = wb_req && WB_WE_I;
    assign mapped = (idx == `PEF_IDX_CFG) || (idx == `PEF_IDX_STAT)
                 || ((idx >= `PEF_IDX_A0) && (idx < `PEF_IDX_A0 + 11'(2 * TAPS))
                     && !idx[0])
                 || ((idx >= `PEF_IDX_B_BASE) && (idx < `PEF_IDX_B_BASE + 11'(2 * TAPS))
                     && !idx[0]);

    // Configuration and status next values
    always_comb begin
        cfg_d   = cfg_q;
        badwr_d = badwr_q;
        if (wb_wr && (idx == `PEF_IDX_CFG) && WB_SEL_I[0]) begin
            cfg_d = pefir_pkg::pefir_cfg_s'(WB_DAT_I[6:0]);
        end
        if (wb_wr && (idx == `PEF_IDX_STAT) && WB_SEL_I[0] && WB_DAT_I[`PEF_STAT_BADWR]) begin
            badwr_d = 1'b0;
        end
        // A late write is still taken; the flag only reports it, and set wins
        if (wb_wr && mapped && (idx != `PEF_IDX_STAT) && SERIAL_LINK_ENABLE) begin
            badwr_d = 1'b1; // see [RQ8]
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            cfg_q   <= pefir_pkg::pefir_cfg_s'(`PEF_CFG_RST); // see [RQ12]
            badwr_q <= 1'b0;
        end else begin
            cfg_q   <= cfg_d;
            badwr_q <= badwr_d;
        end
    end

    // One coefficient pair per tap; A taps at 0x418 upward in steps of two
    for (genvar t = 0; t < TAPS; t++) begin : g_tap
        localparam logic [10:0] IDX_A = `PEF_IDX_A0 + 11'(2 * t); // see [RQ10] see [RQ11] see [RQ13]
        localparam logic [10:0] IDX_B = `PEF_IDX_B_BASE + 11'(2 * t);
        localparam logic [17:0] MASK  = (t == `PEF_CENTER) ? `PEF_CTR_MASK : `PEF_SIDE_MASK;
        logic [31:0] mix_a;
        logic [31:0] mix_b;

        assign mix_a = lane_mix({14'h0000, coef_a_q[t]}, WB_DAT_I, WB_SEL_I);
        assign mix_b = lane_mix({14'h0000, coef_b_q[t]}, WB_DAT_I, WB_SEL_I);

        always_comb begin
            coef_a_d[t] = coef_a_q[t];
            coef_b_d[t] = coef_b_q[t];
            if (wb_wr && (idx == IDX_A)) begin
                coef_a_d[t] = mix_a[17:0] & MASK; // see [RQ9] see [RQ14]
            end
            if (wb_wr && (idx == IDX_B)) begin
                coef_b_d[t] = mix_b[17:0] & MASK; // see [RQ9]
            end
        end

        always_ff @(posedge CLK_SYS) begin
            if (!RST_N) begin
                coef_a_q[t] <= '0;
                coef_b_q[t] <= '0;
            end else begin
                coef_a_q[t] <= coef_a_d[t];
                coef_b_q[t] <= coef_b_d[t];
            end
        end

        // Merged mode interleaves the two histories newest first
        if (t % 2 == 0) begin : g_even
            assign win_a[t] = cfg_q.merge ? ha_q[t / 2] : ha_q[t]; // see [RQ2]
            assign win_b[t] = cfg_q.merge ? hb_q[t / 2] : hb_q[t]; // see [RQ2]
        end else begin : g_odd
            assign win_a[t] = cfg_q.merge ? hb_q[(t + 1) / 2] : ha_q[t]; // see [RQ2]
            assign win_b[t] = cfg_q.merge ? ha_q[(t - 1) / 2] : hb_q[t]; // see [RQ2]
        end
    end

    // Read mux and ack; unmapped reads return zero with a normal ack
    always_comb begin
        ack_d  = wb_req;
        rdat_d = rdat_q;
        if (wb_req && !WB_WE_I) begin
            rdat_d = 32'h0000_0000;
            if (idx == `PEF_IDX_CFG) begin
                rdat_d[6:0] = cfg_q;
            end else if (idx == `PEF_IDX_STAT) begin
                rdat_d[`PEF_STAT_LINK]   = SERIAL_LINK_ENABLE;
                rdat_d[`PEF_STAT_BADWR]  = badwr_q;
                rdat_d[`PEF_STAT_ACTIVE] = enabled;
            end else begin
                for (int k = 0; k < TAPS; k++) begin
                    if (idx == `PEF_IDX_A0 + 11'(2 * k)) begin
                        rdat_d[17:0] = coef_a_q[k];
                    end else if (idx == `PEF_IDX_B_BASE + 11'(2 * k)) begin
                        rdat_d[17:0] = coef_b_q[k];
                    end
                end
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q  <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    assign WB_ACK_O = ack_q;
    assign WB_DAT_O = rdat_q;

    // Reserved modes act as off; weights above six are clipped to six
    assign enabled    = (cfg_q.mode == `PEF_MODE_ON); // see [RQ6]
    assign scw_eff    = (cfg_q.scw > `PEF_SCW_MAX) ? `PEF_SCW_MAX : cfg_q.scw; // see [RQ4]
    assign coef_b_use = cfg_q.share ? coef_a_q : coef_b_q; // see [RQ1]

    // Sample intake stalls while the computed pair waits for FIFO room
    assign SMP_READY = !pend_q || fifo_in_ready;
    assign smp_take  = SMP_VALID && SMP_READY;

    // History next values; newest sample at entry zero
    always_comb begin
        ha_d   = ha_q;
        hb_d   = hb_q;
        pend_d = pend_q;
        if (pend_q && fifo_in_ready) begin
            pend_d = 1'b0;
        end
        if (smp_take) begin
            ha_d   = {ha_q[7:0], SMP_A};
            hb_d   = {hb_q[7:0], SMP_B};
            pend_d = 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            ha_q   <= '0;
            hb_q   <= '0;
            pend_q <= 1'b0;
        end else begin
            ha_q   <= ha_d;
            hb_q   <= hb_d;
            pend_q <= pend_d;
        end
    end

    // Bypass keeps the raw sample; filter output is the nine-tap sum
    always_comb begin
        res.a = enabled ? fir_eval(win_a, coef_a_q, scw_eff) : ha_q[0]; // see [RQ15]
        res.b = enabled ? fir_eval(win_b, coef_b_use, scw_eff) : hb_q[0]; // see [RQ15]
    end

    pefir_fifo #(
        .WIDTH ($bits(pefir_pkg::pefir_pair_s)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (CLK_SYS),
        .rst_n     (RST_N),
        .in_valid  (pend_q),
        .in_ready  (fifo_in_ready),
        .in_data   (res),
        .out_valid (OUT_VALID),
        .out_ready (OUT_READY),
        .out_data  (fifo_out)
    );

    assign OUT_A = fifo_out.a;
    assign OUT_B = fifo_out.b;
endmodule : pefir_top

`default_nettype wire

/* File: tb/pefir_chk.sv */
/*
 Port assertions for the equalizer filter top.
 Assumes one clock, a synchronous active-low reset and the bind below.
*/
`timescale 1ns/1ps
`default_nettype none
module pefir_chk (
    input wire logic        CLK_SYS,
    input wire logic        RST_N,
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_WE_I,
    input wire logic        WB_ACK_O,
    input wire logic [31:0] WB_DAT_O,
    input wire logic        SMP_VALID,
    input wire logic        SMP_READY,
    input wire logic        OUT_VALID,
    input wire logic        OUT_READY,
    input wire logic [11:0] OUT_A,
    input wire logic [11:0] OUT_B
);
    // Open request; ack gates a held request so it is not taken twice
    logic req;
    assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held past one cycle");
    ack_cause_a: assert property ($rose(WB_ACK_O) |-> $past(req))
        else $error("ack without request");
    ack_timely_a: assert property (req |=> WB_ACK_O)
        else $error("ack not one cycle after request");
    rst_state_a: assert property ($rose(RST_N) |-> !WB_ACK_O && !OUT_VALID && SMP_READY)
        else $error("outputs not idle after reset");
    rdata_hold_a: assert property (!(req && !WB_WE_I) |=> $stable(WB_DAT_O))
        else $error("read data moved without a read");
    out_hold_a: assert property (OUT_VALID && !OUT_READY |=>
        OUT_VALID && $stable(OUT_A) && $stable(OUT_B))
        else $error("result changed while stalled");
    refuse_full_a: assert property (!SMP_READY |-> OUT_VALID)
        else $error("sample refused with empty buffer");
    take_out_a: assert property (SMP_VALID && SMP_READY |-> ##[1:2] OUT_VALID)
        else $error("taken sample gave no result");
    ready_back_a: assert property (OUT_VALID && OUT_READY && !SMP_READY |=> SMP_READY)
        else $error("ready not back after pop");

    // Main scenarios reached
    wr_c: cover property (req && WB_WE_I);
    full_c: cover property (!SMP_READY);
    pop_c: cover property (OUT_VALID && OUT_READY);
endmodule : pefir_chk

bind pefir_top pefir_chk chk (.CLK_SYS, .RST_N, .WB_CYC_I, .WB_STB_I, .WB_WE_I,
    .WB_ACK_O, .WB_DAT_O, .SMP_VALID, .SMP_READY, .OUT_VALID, .OUT_READY, .OUT_A, .OUT_B);
`default_nettype wire

/* File: tb/pefir_sink.sv */
/*
 Downstream sink model that collects filter results.
 Assumes the bench drives stall and reads the got queue.
*/
`timescale 1ns/1ps
`default_nettype none
module pefir_sink (
    input  wire logic        clk,
    input  wire logic        stall,
    input  wire logic        out_valid,
    input  wire logic [11:0] out_a,
    input  wire logic [11:0] out_b,
    output logic             out_ready
);
    pefir_pkg::pefir_pair_s got[$];
    initial out_ready = 1'b0;
    // Ready follows stall one edge late, as a registered consumer would
    always @(posedge clk) begin
        if (out_valid && out_ready)
            got.push_back('{b: out_b, a: out_a});
        out_ready <= !stall;
    end
endmodule : pefir_sink
`default_nettype wire

/* File: tb/pefir_tb_top.sv */
/*
 Self-checking bench of the equalizer filter top.
 Assumes the sink model and the bound checker.
*/
`include "pefir_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module pefir_tb_top;
    logic        CLK_SYS = 1'b0, RST_N = 1'b0, WB_WE_I = 1'b0, WB_STB_I = 1'b0;
    logic        WB_CYC_I = 1'b0, SERIAL_LINK_ENABLE = 1'b0, SMP_VALID = 1'b0;
    logic        stall = 1'b0, WB_ACK_O, SMP_READY, OUT_VALID, OUT_READY;
    logic [3:0]  WB_SEL_I = 4'hf;
    logic [12:0] WB_ADR_I = 13'h0000;
    logic [31:0] WB_DAT_I = 32'h0, WB_DAT_O, rd;
    logic [11:0] SMP_A = 12'h000, SMP_B = 12'h000, OUT_A, OUT_B;
    int          n_mismatch = 0;
    int          comparisons = 0;

    always #12.5 CLK_SYS = ~CLK_SYS;

    pefir_top dut (.CLK_SYS, .RST_N, .WB_ADR_I, .WB_DAT_I, .WB_DAT_O, .WB_WE_I,
        .WB_SEL_I, .WB_STB_I, .WB_CYC_I, .WB_ACK_O, .SERIAL_LINK_ENABLE, .SMP_VALID,
        .SMP_READY, .SMP_A, .SMP_B, .OUT_VALID, .OUT_READY, .OUT_A, .OUT_B);
    pefir_sink snk (.clk(CLK_SYS), .stall(stall), .out_valid(OUT_VALID), .out_a(OUT_A),
        .out_b(OUT_B), .out_ready(OUT_READY));

    task automatic tally_and_finish;
        if (n_mismatch == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic chk_out(input int i, input logic [11:0] ea, eb);
        chk("out_a", {20'h0, snk.got[i].a}, {20'h0, ea});
        chk("out_b", {20'h0, snk.got[i].b}, {20'h0, eb});
    endtask : chk_out

    // A wait that runs out ends the run as a failure
    task automatic hang;
        n_mismatch++;
        tally_and_finish();
    endtask : hang

    task automatic rst;
        RST_N <= 1'b0;
        repeat (16) @(posedge CLK_SYS);
        RST_N <= 1'b1;
        snk.got.delete();
    endtask : rst

    // One classic cycle; the request stands until ack is sampled
    task automatic wb(input logic we, input logic [10:0] idx, input logic [31:0] d);
        int n;
        n = 0;
        WB_ADR_I <= {idx, 2'b00};
        WB_WE_I <= we;
        WB_DAT_I <= d;
        WB_CYC_I <= 1'b1;
        WB_STB_I <= 1'b1;
        do begin
            @(posedge CLK_SYS);
            n++;
        end while (WB_ACK_O !== 1'b1 && n < 20);
        if (WB_ACK_O !== 1'b1)
            hang();
        rd = WB_DAT_O;
        WB_CYC_I <= 1'b0;
        WB_STB_I <= 1'b0;
        @(posedge CLK_SYS);
    endtask : wb

    // Valid stays up between sends so back-to-back pairs go every cycle
    task automatic send(input logic [11:0] a, b);
        int n;
        n = 0;
        SMP_A <= a;
        SMP_B <= b;
        SMP_VALID <= 1'b1;
        do begin
            @(posedge CLK_SYS);
            n++;
        end while (SMP_READY !== 1'b1 && n < 20);
        if (SMP_READY !== 1'b1)
            hang();
    endtask : send

    // Released sample lines show inverted data, never the old value
    task automatic idle;
        SMP_VALID <= 1'b0;
        SMP_A <= ~SMP_A;
        SMP_B <= ~SMP_B;
    endtask : idle

    task automatic drain(input int k);
        int n;
        for (n = 0; n < 100 && snk.got.size() < k; n++)
            @(posedge CLK_SYS);
        if (snk.got.size() < k)
            hang();
    endtask : drain

    function automatic logic [31:0] cfgv(input logic sh, mg, input logic [1:0] md);
        return {25'h0, sh, mg, 3'h6, md};
    endfunction : cfgv

    task automatic load_taps;
        for (int t = 0; t < 3; t++)
            wb(1, `PEF_IDX_A0 + 11'(2 * t), 32'h200);
    endtask : load_taps

    task automatic t_regs;
        wb(0, `PEF_IDX_CFG, 0);
        chk("cfg_reset", rd, 32'h0);
        wb(1, `PEF_IDX_CFG, 32'hffff_ffff);
        wb(0, `PEF_IDX_CFG, 0);
        chk("cfg_reserved", rd, 32'h7f);
        for (int t = 0; t < 3; t++)
            wb(1, `PEF_IDX_A0 + 11'(2 * t), 32'hffff_f000 | (32'h123 << t));
        for (int t = 0; t < 3; t++) begin
            wb(0, `PEF_IDX_A0 + 11'(2 * t), 0);
            chk("tap_rw", rd, 32'h123 << t);
        end
        // Center tap keeps all 18 bits, side taps only 12
        wb(1, `PEF_IDX_A0 + 11'h8, 32'hffff_ffff);
        wb(0, `PEF_IDX_A0 + 11'h8, 0);
        chk("center_rw", rd, 32'h3_ffff);
        wb(0, 11'h7ff, 0);
        chk("unmapped", rd, 32'h0);
        SERIAL_LINK_ENABLE <= 1'b1;
        wb(1, `PEF_IDX_CFG, 0);
        wb(0, `PEF_IDX_STAT, 0);
        chk("link_write", rd & 32'h3, 32'h3);
        SERIAL_LINK_ENABLE <= 1'b0;
        wb(1, `PEF_IDX_STAT, 32'h2);
        wb(0, `PEF_IDX_STAT, 0);
        chk("link_clear", rd & 32'h3, 32'h0);
    endtask : t_regs

    // Only mode 2 filters; gain of tap0 is one half at weight 6
    task automatic t_modes;
        rst();
        wb(1, `PEF_IDX_A0, 32'h200);
        for (int m = 0; m < 4; m++) begin
            wb(1, `PEF_IDX_CFG, cfgv(0, 0, 2'(m)));
            wb(0, `PEF_IDX_STAT, 0);
            chk("active", rd & 32'h4, m == 2 ? 32'h4 : 32'h0);
            send(12'h100, 12'h040);
            idle();
            drain(m + 1);
            chk_out(m, m == 2 ? 12'h080 : 12'h100, m == 2 ? 12'h000 : 12'h040);
        end
        // Weight 0 leaves tap0 at its plain 2^-16 LSB
        wb(1, `PEF_IDX_CFG, 32'h2);
        send(12'h100, 12'h040);
        idle();
        drain(5);
        chk_out(4, 12'h002, 12'h000);
    endtask : t_modes

    // B center of 1.0 must ignore the side weight; it first sees a sample on
    // the fifth pair; share swaps it out for the A set
    task automatic t_fir(input logic sh);
        logic [11:0] ea;
        logic [11:0] eb;
        rst();
        load_taps();
        wb(1, `PEF_IDX_B_BASE + 11'h8, 32'h1_0000);
        wb(1, `PEF_IDX_CFG, cfgv(sh, 0, 2'h2));
        for (int k = 0; k < 5; k++)
            send(12'h100, 12'h040);
        idle();
        drain(5);
        for (int k = 0; k < 5; k++) begin
            ea = 12'(128 * (k < 3 ? k + 1 : 3));
            eb = sh ? 12'(32 * (k < 3 ? k + 1 : 3)) : (k == 4 ? 12'h040 : 12'h000);
            chk_out(k, ea, eb);
        end
    endtask : t_fir

    task automatic t_merge;
        rst();
        load_taps();
        wb(1, `PEF_IDX_CFG, cfgv(1, 1, 2'h2));
        send(12'h100, 12'h040);
        send(12'h100, 12'h040);
        idle();
        drain(2);
        chk_out(0, 12'h080, 12'h0a0);
        chk_out(1, 12'h120, 12'h0c0);
    endtask : t_merge

    // Eight buffered plus one pending, then refusal until the first pop frees room
    task automatic t_fifo;
        rst();
        stall <= 1'b1;
        for (int k = 0; k < 9; k++)
            send(12'(k), 12'(k + 16));
        idle();
        repeat (2) @(posedge CLK_SYS);
        chk("ready_full", {31'h0, SMP_READY}, 32'h0);
        stall <= 1'b0;
        drain(9);
        for (int k = 0; k < 9; k++)
            chk_out(k, 12'(k), 12'(k + 16));
    endtask : t_fifo

    initial begin
        rst();
        t_regs();
        t_modes();
        t_fir(1'b0);
        t_fir(1'b1);
        t_merge();
        t_fifo();
        tally_and_finish();
    end
endmodule : pefir_tb_top
`default_nettype wire
